// >>> rtl/mxb_pkg.sv
package mxb_pkg;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int          SYS_CLK_PERIOD_NS = 8;
    localparam int          BUS_PERIOD_NS     = 50;
    // least time per bus period, rounded up to whole system clocks
    localparam int          PERIOD_CYC        = (BUS_PERIOD_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
    localparam int          CNT_W             = $clog2(PERIOD_CYC);
    localparam logic [CNT_W-1:0] PERIOD_LAST  = CNT_W'(PERIOD_CYC - 1);
    localparam logic [CNT_W-1:0] ALE_HIGH_CYC = CNT_W'(PERIOD_CYC / 2);
    localparam logic [CNT_W-1:0] RD_LEAD_CYC  = CNT_W'(1);
    localparam logic [CNT_W-1:0] CAPTURE_CYC  = CNT_W'(2);
    localparam int          SYNC_STAGES       = 2;

    // ************************************************************
    // widths and reset values
    // ************************************************************
    localparam int          BYTE_W            = 8;
    localparam int          WORD_W            = 16;
    localparam int          ADDR_LO_W         = 3;
    localparam int          WAIT_W            = 4;
    localparam logic [BYTE_W-1:0] AD_RESET    = 8'h00;
    localparam logic [WORD_W-1:0] WORD_RESET  = 16'h0000;
    localparam logic [ADDR_LO_W-1:0] ALO_RESET = 3'h0;
    localparam logic [WAIT_W-1:0] WAIT_RESET  = 4'h0;

    // ************************************************************
    // sequencer states
    // ************************************************************
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_FIRST_PERIOD,
        ST_T2,
        ST_T3,
        ST_TW,
        ST_T4,
        ST_HOLD
    } mxb_state_e;

endpackage

// >>> rtl/mxb_sync.sv
`timescale 1ns/1ps
`default_nettype none
module mxb_sync
    import mxb_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input  wire logic             i_sys_clk,
    input  wire logic             i_srst,
    input  wire logic             i_clk_en,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);

    // ************************************************************
    // two-stage synchroniser; first stage feeds only the second
    // ************************************************************
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] next_sync;

    always_comb begin
        next_meta = meta;
        next_sync = o_sync;
        if (i_clk_en) begin
            next_meta = i_async;
            next_sync = meta;
        end
        if (i_srst) begin
            next_meta = '0;
            next_sync = '0;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        meta   <= next_meta;
        o_sync <= next_sync;
    end

endmodule
`default_nettype wire

// >>> rtl/mxb_period_timer.sv
`timescale 1ns/1ps
`default_nettype none
module mxb_period_timer
    import mxb_pkg::*;
#(
    parameter logic [CNT_W-1:0] LAST = PERIOD_LAST
) (
    input  wire logic             i_sys_clk,
    input  wire logic             i_srst,
    input  wire logic             i_clk_en,
    input  wire logic             i_run,
    output logic      [CNT_W-1:0] o_cnt,
    output logic                  o_last
);

    // ************************************************************
    // cycle counter inside one bus period
    // ************************************************************
    logic [CNT_W-1:0] next_cnt;

    assign o_last = i_run && (o_cnt == LAST);

    always_comb begin
        next_cnt = o_cnt;
        if (i_clk_en) begin
            if (!i_run || o_last) begin
                next_cnt = '0;
            end else begin
                next_cnt = o_cnt + CNT_W'(1);
            end
        end
        if (i_srst) begin
            next_cnt = '0;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        o_cnt <= next_cnt;
    end

endmodule
`default_nettype wire

// >>> rtl/mxb_bus_port.sv
// Notes on behaviour
// R1: address low byte on shared lines in first period, data in periods two to four.
// R2: wide access in byte mode runs two byte cycles, low byte then high byte.
// R3: shared address/data lines float during bus hold and during reset.
// R4: three dedicated low address lines, not multiplexed, cover eight bytes.
// R5: dedicated low address lines float during bus hold and reset.
// R6: latch strobe pulses while address is stable; address valid at falling edge.
// R7: latch strobe floats with pull low in hold; reset pull only if enabled.
// R8: read strobe asserts only after shared lines are released for data.
// R9: read strobe floats for the whole bus hold.
// R10: write strobe marks write data on shared lines; floats in hold or reset.
// R11: outside logic latches low address on latch strobe trailing edge.
// R12: read and write strobes active low; outside drives data only during read strobe.
`timescale 1ns/1ps
`default_nettype none
module mxb_bus_port
    import mxb_pkg::*;
(
    input  wire logic                 i_sys_clk,
    input  wire logic                 i_srst,
    input  wire logic                 i_clk_en,
    // request side
    input  wire logic                 i_req_valid,
    output logic                      o_req_ready,
    input  wire logic                 i_req_write,
    input  wire logic                 i_req_wide,
    input  wire logic [BYTE_W-1:0]    i_req_addr,
    input  wire logic [WORD_W-1:0]    i_req_wdata,
    input  wire logic [WAIT_W-1:0]    i_wait_periods,
    output logic                      o_rsp_valid,
    output logic      [WORD_W-1:0]    o_rsp_rdata,
    // hold and pull control
    input  wire logic                 i_bus_hold,
    output logic                      o_hold_ack,
    input  wire logic                 i_ale_pull_en,
    output logic                      o_ale_pull_low,
    // shared address/data pins
    input  wire logic [BYTE_W-1:0]    i_ad,
    output logic      [BYTE_W-1:0]    o_ad,
    output logic                      o_ad_oe_n,
    // dedicated low address pins
    output logic      [ADDR_LO_W-1:0] o_addr_lo,
    output logic                      o_addr_lo_oe_n,
    // strobes
    output logic                      o_ale,
    output logic                      o_ale_oe_n,
    output logic                      o_rd_n,
    output logic                      o_rd_oe_n,
    output logic                      o_wr_n,
    output logic                      o_wr_oe_n
);

    // ************************************************************
    // declarations
    // ************************************************************
    mxb_state_e        state;
    mxb_state_e        next_state;
    logic              cyc_write;
    logic              next_cyc_write;
    logic              cyc_wide;
    logic              next_cyc_wide;
    logic              high_byte;
    logic              next_high_byte;
    logic [BYTE_W-1:0] cyc_addr;
    logic [BYTE_W-1:0] next_cyc_addr;
    logic [WORD_W-1:0] cyc_wdata;
    logic [WORD_W-1:0] next_cyc_wdata;
    logic [WAIT_W-1:0] wait_left;
    logic [WAIT_W-1:0] next_wait_left;
    logic [WORD_W-1:0] next_rsp_rdata;
    logic              next_rsp_valid;

    logic [BYTE_W-1:0]    next_ad;
    logic                 next_ad_oe_n;
    logic [ADDR_LO_W-1:0] next_addr_lo;
    logic                 next_addr_lo_oe_n;
    logic                 next_ale;
    logic                 next_ale_oe_n;
    logic                 next_rd_n;
    logic                 next_rd_oe_n;
    logic                 next_wr_n;
    logic                 next_wr_oe_n;

    logic [CNT_W-1:0]  cnt;
    logic              period_end;
    logic              in_cycle;
    logic [BYTE_W-1:0] ad_sync;
    logic              accept;

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic data_period(input mxb_state_e st);
        data_period = (st == ST_T2) || (st == ST_T3) || (st == ST_TW) || (st == ST_T4);
    endfunction

    function automatic logic [BYTE_W-1:0] byte_of(input logic [WORD_W-1:0] w, input logic hi);
        byte_of = hi ? w[WORD_W-1:BYTE_W] : w[BYTE_W-1:0];
    endfunction

    assign in_cycle    = (state == ST_FIRST_PERIOD) || data_period(state);
    // a hold is granted only between bus cycles so no cycle is torn
    assign o_req_ready = (state == ST_IDLE) && !i_bus_hold && !i_srst;
    assign accept      = o_req_ready && i_req_valid;
    assign o_hold_ack  = (state == ST_HOLD);
    // pull acts in hold always, in reset only when enabled
    assign o_ale_pull_low = o_hold_ack || (i_srst && i_ale_pull_en); // R7

    // ************************************************************
    // submodules
    // ************************************************************
    mxb_period_timer #(
        .LAST      (PERIOD_LAST)
    ) u_timer (
        .i_sys_clk (i_sys_clk),
        .i_srst    (i_srst),
        .i_clk_en  (i_clk_en),
        .i_run     (in_cycle),
        .o_cnt     (cnt),
        .o_last    (period_end)
    );

    // read data arrive from the pins, so they cross two stages first
    mxb_sync #(
        .WIDTH     (BYTE_W)
    ) u_ad_sync (
        .i_sys_clk (i_sys_clk),
        .i_srst    (i_srst),
        .i_clk_en  (i_clk_en),
        .i_async   (i_ad),
        .o_sync    (ad_sync)
    );

    // ************************************************************
    // sequencer
    // ************************************************************
    always_comb begin
        next_state     = state;
        next_cyc_write = cyc_write;
        next_cyc_wide  = cyc_wide;
        next_high_byte = high_byte;
        next_cyc_addr  = cyc_addr;
        next_cyc_wdata = cyc_wdata;
        next_wait_left = wait_left;
        next_rsp_rdata = o_rsp_rdata;
        next_rsp_valid = 1'b0;
        if (i_clk_en) begin
            case (state)
                ST_IDLE: begin
                    if (i_bus_hold) begin
                        next_state = ST_HOLD;
                    end else if (accept) begin
                        next_state     = ST_FIRST_PERIOD;
                        next_cyc_write = i_req_write;
                        next_cyc_wide  = i_req_wide;
                        next_cyc_addr  = i_req_addr;
                        next_cyc_wdata = i_req_wdata;
                        next_high_byte = 1'b0;
                        next_rsp_rdata = WORD_RESET;
                    end
                end
                ST_FIRST_PERIOD: begin
                    if (period_end) begin
                        next_state = ST_T2;
                    end
                end
                ST_T2: begin
                    if (period_end) begin
                        next_state     = ST_T3;
                        next_wait_left = i_wait_periods;
                    end
                end
                ST_T3, ST_TW: begin
                    if (period_end) begin
                        if (wait_left != WAIT_RESET) begin
                            next_state     = ST_TW;
                            next_wait_left = wait_left - WAIT_W'(1);
                        end else begin
                            next_state = ST_T4;
                        end
                    end
                end
                ST_T4: begin
                    // pin level seen under the read strobe, two stages late
                    if (!cyc_write && (cnt == CAPTURE_CYC)) begin
                        if (high_byte) begin
                            next_rsp_rdata[WORD_W-1:BYTE_W] = ad_sync;
                        end else begin
                            next_rsp_rdata[BYTE_W-1:0] = ad_sync;
                        end
                    end
                    if (period_end) begin
                        if (cyc_wide && !high_byte) begin
                            next_state     = ST_FIRST_PERIOD; // R2
                            next_high_byte = 1'b1;
                            next_cyc_addr  = cyc_addr + BYTE_W'(1);
                        end else begin
                            next_state     = ST_IDLE;
                            next_rsp_valid = 1'b1;
                        end
                    end
                end
                ST_HOLD: begin
                    if (!i_bus_hold) begin
                        next_state = ST_IDLE;
                    end
                end
                default: begin
                    next_state = ST_IDLE;
                end
            endcase
        end else begin
            next_rsp_valid = o_rsp_valid;
        end
        if (i_srst) begin
            next_state     = ST_IDLE;
            next_cyc_write = 1'b0;
            next_cyc_wide  = 1'b0;
            next_high_byte = 1'b0;
            next_cyc_addr  = AD_RESET;
            next_cyc_wdata = WORD_RESET;
            next_wait_left = WAIT_RESET;
            next_rsp_rdata = WORD_RESET;
            next_rsp_valid = 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        state       <= next_state;
        cyc_write   <= next_cyc_write;
        cyc_wide    <= next_cyc_wide;
        high_byte   <= next_high_byte;
        cyc_addr    <= next_cyc_addr;
        cyc_wdata   <= next_cyc_wdata;
        wait_left   <= next_wait_left;
        o_rsp_rdata <= next_rsp_rdata;
        o_rsp_valid <= next_rsp_valid;
    end

    // ************************************************************
    // pin drivers, registered one cycle behind the sequencer
    // ************************************************************
    always_comb begin
        next_ad           = o_ad;
        next_ad_oe_n      = o_ad_oe_n;
        next_addr_lo      = o_addr_lo;
        next_addr_lo_oe_n = o_addr_lo_oe_n;
        next_ale          = o_ale;
        next_ale_oe_n     = o_ale_oe_n;
        next_rd_n         = o_rd_n;
        next_rd_oe_n      = o_rd_oe_n;
        next_wr_n         = o_wr_n;
        next_wr_oe_n      = o_wr_oe_n;
        if (i_clk_en) begin
            next_ad_oe_n      = 1'b1;
            next_addr_lo_oe_n = 1'b0;
            next_ale          = 1'b0;
            next_ale_oe_n     = 1'b0;
            next_rd_n         = 1'b1;
            next_rd_oe_n      = 1'b0;
            next_wr_n         = 1'b1;
            next_wr_oe_n      = 1'b0;
            next_addr_lo      = cyc_addr[ADDR_LO_W-1:0]; // R4
            if (state == ST_FIRST_PERIOD) begin
                next_ad      = cyc_addr; // R1
                next_ad_oe_n = 1'b0;
                // strobe falls mid-period while address still stands
                next_ale     = (cnt < ALE_HIGH_CYC); // R6
            end else if (data_period(state) && cyc_write) begin
                next_ad      = byte_of(cyc_wdata, high_byte); // R1
                next_ad_oe_n = 1'b0;
                // released at the start of t4 so data still stand at the rising edge
                next_wr_n    = (state == ST_T4); // R10
            end else if (data_period(state)) begin
                // lines already floated; strobe lags release by one cycle
                next_rd_n = (state == ST_T4) || ((state == ST_T2) && (cnt < RD_LEAD_CYC)); // R8
            end
            if (state == ST_HOLD) begin
                next_ad_oe_n      = 1'b1; // R3
                next_addr_lo_oe_n = 1'b1; // R5
                next_ale_oe_n     = 1'b1; // R7
                next_rd_oe_n      = 1'b1; // R9
                next_wr_oe_n      = 1'b1; // R10
            end
        end
        if (i_srst) begin
            next_ad           = AD_RESET;
            next_ad_oe_n      = 1'b1; // R3
            next_addr_lo      = ALO_RESET;
            next_addr_lo_oe_n = 1'b1; // R5
            next_ale          = 1'b0;
            next_ale_oe_n     = 1'b1; // R7
            next_rd_n         = 1'b1;
            next_rd_oe_n      = 1'b0;
            next_wr_n         = 1'b1;
            next_wr_oe_n      = 1'b1; // R10
        end
    end

    always_ff @(posedge i_sys_clk) begin
        o_ad           <= next_ad;
        o_ad_oe_n      <= next_ad_oe_n;
        o_addr_lo      <= next_addr_lo;
        o_addr_lo_oe_n <= next_addr_lo_oe_n;
        o_ale          <= next_ale;
        o_ale_oe_n     <= next_ale_oe_n;
        o_rd_n         <= next_rd_n; // R12
        o_rd_oe_n      <= next_rd_oe_n;
        o_wr_n         <= next_wr_n; // R12
        o_wr_oe_n      <= next_wr_oe_n;
    end

endmodule
`default_nettype wire

// >>> tb/mxb_bus_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module mxb_bus_monitor
    import mxb_pkg::*;
(
    input  wire logic                 i_sys_clk,
    input  wire logic                 i_srst,
    input  wire logic                 o_hold_ack,
    input  wire logic                 o_ale_pull_low,
    input  wire logic [BYTE_W-1:0]    o_ad,
    input  wire logic                 o_ad_oe_n,
    input  wire logic [ADDR_LO_W-1:0] o_addr_lo,
    input  wire logic                 o_addr_lo_oe_n,
    input  wire logic                 o_ale,
    input  wire logic                 o_ale_oe_n,
    input  wire logic                 o_rd_n,
    input  wire logic                 o_rd_oe_n,
    input  wire logic                 o_wr_n,
    input  wire logic                 o_wr_oe_n
);
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_srst);

    // ************************************************************
    // sequences
    // ************************************************************
    sequence s_ale_pulse;
        o_ale [*3] ##1 !o_ale;
    endsequence
    sequence s_rd_low_span;
        !o_rd_n [*8];
    endsequence
    sequence s_hold_settled;
        $past(o_hold_ack) && o_hold_ack;
    endsequence

    // ************************************************************
    // assertions
    // ************************************************************
    a_ale_pulse_len: assert property ($rose(o_ale) |-> s_ale_pulse) else $error("latch strobe pulse length");
    a_ale_addr_stable: assert property ($fell(o_ale) |-> !o_ad_oe_n && $stable(o_ad)) else $error("addr moved");
    a_ale_addr_driven: assert property (o_ale |-> !o_ad_oe_n) else $error("address not driven in strobe");
    a_addr_lo_match: assert property (o_ale |-> !o_addr_lo_oe_n && o_addr_lo == o_ad[ADDR_LO_W-1:0])
        else $error("low address lines differ");
    a_rd_after_float: assert property ($fell(o_rd_n) |-> $past(o_ad_oe_n) && o_ad_oe_n)
        else $error("read strobe before release");
    a_rd_low_span: assert property ($fell(o_rd_n) |-> s_rd_low_span) else $error("read strobe too short");
    a_wr_data_on: assert property (!o_wr_n |-> !o_ad_oe_n && !o_wr_oe_n) else $error("write without data");
    a_strobes_apart: assert property (!(!o_rd_n && !o_wr_n)) else $error("both strobes low");
    a_hold_ad_float: assert property (s_hold_settled |-> o_ad_oe_n) else $error("shared lines driven in hold");
    a_hold_alo_float: assert property (s_hold_settled |-> o_addr_lo_oe_n) else $error("low address in hold");
    a_hold_rd_float: assert property (s_hold_settled |-> o_rd_oe_n) else $error("read strobe in hold");
    a_hold_wr_float: assert property (s_hold_settled |-> o_wr_oe_n) else $error("write strobe in hold");
    a_hold_ale_pull: assert property (s_hold_settled |-> o_ale_oe_n && o_ale_pull_low)
        else $error("latch strobe in hold");
    a_pull_only_hold: assert property (!o_hold_ack |-> !o_ale_pull_low) else $error("pull outside hold");
endmodule

bind mxb_bus_port mxb_bus_monitor u_mon (
    .i_sys_clk(i_sys_clk), .i_srst(i_srst), .o_hold_ack(o_hold_ack), .o_ale_pull_low(o_ale_pull_low),
    .o_ad(o_ad), .o_ad_oe_n(o_ad_oe_n), .o_addr_lo(o_addr_lo), .o_addr_lo_oe_n(o_addr_lo_oe_n),
    .o_ale(o_ale), .o_ale_oe_n(o_ale_oe_n), .o_rd_n(o_rd_n), .o_rd_oe_n(o_rd_oe_n),
    .o_wr_n(o_wr_n), .o_wr_oe_n(o_wr_oe_n)
);
`default_nettype wire

// >>> tb/mxb_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module mxb_mem_model
    import mxb_pkg::*;
(
    input  wire logic              i_clk,
    input  wire logic [BYTE_W-1:0] i_ad,
    input  wire logic              i_ad_oe_n,
    input  wire logic              i_ale,
    input  wire logic              i_rd_n,
    input  wire logic              i_rd_oe_n,
    input  wire logic              i_wr_n,
    input  wire logic              i_wr_oe_n,
    output logic      [BYTE_W-1:0] o_bus
);
    logic [BYTE_W-1:0] mem [256];
    logic [BYTE_W-1:0] addr = 8'h00;
    logic [BYTE_W-1:0] last = 8'h00;
    logic              drv;

    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'(i) ^ 8'h5A;
        end
    end
    always @(negedge i_ale) begin
        if (!i_ad_oe_n) begin
            addr = i_ad;
        end
    end
    always @(posedge i_wr_n) begin
        if (!i_wr_oe_n) begin
            mem[addr] = i_ad;
        end
    end
    assign drv = !i_rd_n && !i_rd_oe_n;
    // a released bus shows a changing pattern, never the last value
    always_comb begin
        if (drv && !i_ad_oe_n) begin
            o_bus = 'x;
        end else if (drv) begin
            o_bus = mem[addr];
        end else if (!i_ad_oe_n) begin
            o_bus = i_ad;
        end else begin
            o_bus = ~last;
        end
    end
    always @(posedge i_clk) begin
        last <= o_bus;
    end
endmodule
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import mxb_pkg::*;
    logic                 i_sys_clk, i_srst, i_clk_en, i_req_valid, i_req_write, i_req_wide;
    logic                 i_bus_hold, i_ale_pull_en, o_req_ready, o_rsp_valid, o_hold_ack, o_ale_pull_low;
    logic                 o_ad_oe_n, o_addr_lo_oe_n, o_ale, o_ale_oe_n, o_rd_n, o_rd_oe_n, o_wr_n, o_wr_oe_n;
    logic [BYTE_W-1:0]    i_req_addr, i_ad, o_ad;
    logic [WORD_W-1:0]    i_req_wdata, o_rsp_rdata;
    logic [WAIT_W-1:0]    i_wait_periods;
    logic [ADDR_LO_W-1:0] o_addr_lo;
    int                   bad_count = 0;
    int                   checks_done = 0;

    mxb_bus_port DUT (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_clk_en(i_clk_en), .i_req_valid(i_req_valid),
        .o_req_ready(o_req_ready), .i_req_write(i_req_write), .i_req_wide(i_req_wide), .i_req_addr(i_req_addr),
        .i_req_wdata(i_req_wdata), .i_wait_periods(i_wait_periods), .o_rsp_valid(o_rsp_valid),
        .o_rsp_rdata(o_rsp_rdata), .i_bus_hold(i_bus_hold), .o_hold_ack(o_hold_ack),
        .i_ale_pull_en(i_ale_pull_en), .o_ale_pull_low(o_ale_pull_low), .i_ad(i_ad), .o_ad(o_ad),
        .o_ad_oe_n(o_ad_oe_n), .o_addr_lo(o_addr_lo), .o_addr_lo_oe_n(o_addr_lo_oe_n), .o_ale(o_ale),
        .o_ale_oe_n(o_ale_oe_n), .o_rd_n(o_rd_n), .o_rd_oe_n(o_rd_oe_n), .o_wr_n(o_wr_n), .o_wr_oe_n(o_wr_oe_n));
    mxb_mem_model u_mem (.i_clk(i_sys_clk), .i_ad(o_ad), .i_ad_oe_n(o_ad_oe_n), .i_ale(o_ale), .i_rd_n(o_rd_n),
        .i_rd_oe_n(o_rd_oe_n), .i_wr_n(o_wr_n), .i_wr_oe_n(o_wr_oe_n), .o_bus(i_ad));

    // ************************************************************
    // compare and report
    // ************************************************************
    task automatic check_word(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic check_flag(input logic got, input logic exp);
        check_word({15'h0000, got}, {15'h0000, exp});
    endtask
    task automatic check_count(input int got, input int exp);
        checks_done++;
        if (got != exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ************************************************************
    // bus transfer, entered and left just after a rising edge
    // ************************************************************
    task automatic xfer(input logic wr, input logic wide, input logic [BYTE_W-1:0] a,
                        input logic [WORD_W-1:0] wd, input logic [WAIT_W-1:0] w, input logic [WORD_W-1:0] exp);
        int n;
        int lat;
        lat = (4 + int'(w)) * PERIOD_CYC * (wide ? 2 : 1) + 1;
        i_req_valid = 1'b1;
        i_req_write = wr;
        i_req_wide = wide;
        i_req_addr = a;
        i_req_wdata = wd;
        i_wait_periods = w;
        n = 0;
        while (o_req_ready !== 1'b1 && n < 50) begin
            @(posedge i_sys_clk);
            #1;
            n++;
        end
        @(posedge i_sys_clk);
        #1;
        i_req_valid = 1'b0;
        n = 1;
        while (o_rsp_valid !== 1'b1 && n < 400) begin
            @(posedge i_sys_clk);
            #1;
            n++;
        end
        check_count(n, lat);
        if (!wr) begin
            check_word(o_rsp_rdata, exp);
        end
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_reset(input logic pen);
        i_srst = 1'b1;
        i_ale_pull_en = pen;
        @(posedge i_sys_clk);
        #1;
        check_flag(o_ad_oe_n, 1'b1);
        check_flag(o_addr_lo_oe_n, 1'b1);
        check_flag(o_wr_oe_n, 1'b1);
        check_flag(o_ale_oe_n, 1'b1);
        check_flag(o_ale_pull_low, pen);
        check_flag(o_req_ready, 1'b0);
        @(posedge i_sys_clk);
        #1;
        i_srst = 1'b0;
        $display("test reset done");
    endtask
    task automatic t_narrow();
        xfer(1'b1, 1'b0, 8'h03, 16'h003C, 4'h0, 16'h0000);
        xfer(1'b0, 1'b0, 8'h03, 16'h0000, 4'h0, 16'h003C);
        xfer(1'b0, 1'b0, 8'h47, 16'h0000, 4'h1, {8'h00, 8'h47 ^ 8'h5A});
        $display("test narrow done");
    endtask
    task automatic t_wide();
        xfer(1'b1, 1'b1, 8'hFF, 16'hBEEF, 4'h2, 16'h0000);
        xfer(1'b0, 1'b1, 8'hFF, 16'h0000, 4'h0, 16'hBEEF);
        xfer(1'b0, 1'b0, 8'h00, 16'h0000, 4'h0, 16'h00BE);
        $display("test wide done");
    endtask
    task automatic t_hold();
        i_bus_hold = 1'b1;
        repeat (2) @(posedge i_sys_clk);
        #1;
        i_req_valid = 1'b1;
        check_flag(o_hold_ack, 1'b1);
        check_flag(o_ad_oe_n, 1'b1);
        check_flag(o_addr_lo_oe_n, 1'b1);
        check_flag(o_rd_oe_n, 1'b1);
        check_flag(o_wr_oe_n, 1'b1);
        check_flag(o_ale_pull_low, 1'b1);
        @(posedge i_sys_clk);
        #1;
        check_flag(o_req_ready, 1'b0);
        i_req_valid = 1'b0;
        i_bus_hold = 1'b0;
        xfer(1'b0, 1'b0, 8'h03, 16'h0000, 4'h0, 16'h003C);
        $display("test hold done");
    endtask
    // a request offered while the enable is low must not start a cycle
    task automatic t_freeze();
        i_clk_en = 1'b0;
        i_req_valid = 1'b1;
        repeat (3) @(posedge i_sys_clk);
        #1;
        check_flag(o_ad_oe_n, 1'b1);
        check_flag(o_ale, 1'b0);
        check_flag(o_rsp_valid, 1'b0);
        i_req_valid = 1'b0;
        i_clk_en = 1'b1;
        $display("test freeze done");
    endtask

    initial begin
        i_sys_clk = 1'b0;
        forever #4 i_sys_clk = ~i_sys_clk;
    end
    initial begin
        repeat (20000) @(posedge i_sys_clk);
        bad_count++;
        summarize();
    end
    initial begin
        {i_clk_en, i_req_valid, i_req_write, i_req_wide, i_bus_hold} = 5'b10000;
        i_req_addr = 8'h00;
        i_req_wdata = 16'h0000;
        i_wait_periods = 4'h0;
        t_reset(1'b1);
        t_freeze();
        t_narrow();
        t_wide();
        t_hold();
        t_reset(1'b0);
        t_narrow();
        summarize();
    end
endmodule
`default_nettype wire
